// ### core/sirq_device.sv
// slave end: reports interrupt levels in their serial slots
`timescale 1ns/10ps
`default_nettype none
module sirq_device (
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        reset_in,
   // interrupt levels, bit n is irq n, low means asserted
   input  wire logic [15:0] irq_level_in,
   // management interrupt, active low, and its routing enables
   input  wire logic        mgmt_interrupt_request_in,
   input  wire logic        mgmt_frame_en_in,
   input  wire logic        mgmt_pin_en_in,
   // dedicated management interrupt pin, active low
   output logic             mgmt_interrupt_line_out,
   // current mode, high for quiet
   output logic             quiet_mode_out,
   // link
   sirq_if.device           link
);
   sirq_pkg::sirq_dev_state_t state_reg;
   logic [1:0]  line_sync_reg;
   logic        line_reg;
   logic [15:0] lvl_sync1_reg;
   logic [1:0]  mgmt_sync_reg;
   logic [15:0] lvl_reg;
   logic [15:0] sent_reg;
   logic        quiet_reg;
   logic [3:0]  low_cnt_reg;
   logic [1:0]  phase_reg;
   logic [4:0]  period_reg;
   logic        drove_low_reg;
   logic        drv_out_reg;
   logic        drv_oe_reg;
   logic        mgmt_line_reg;
   logic [15:0] slot_lvl;
   logic        slot_low;
   logic        rise;

   // slot levels: slot 0 unused, slot 2 shares irq2 and management
   always_comb begin
      slot_lvl    = lvl_reg;
      slot_lvl[0] = 1'b1;
      slot_lvl[2] = lvl_reg[2] & (mgmt_sync_reg[1] | ~mgmt_frame_en_in);
   end

   assign line_reg = line_sync_reg[1];
   assign rise     = line_reg & (low_cnt_reg != sirq_pkg::SIRQ_CNT_RESET);
   assign slot_low = ~slot_lvl[period_reg[3:0]];

   // sample wire on rising edges only
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         line_sync_reg <= 2'h3;
         lvl_sync1_reg <= sirq_pkg::SIRQ_LEVEL_RESET;
         lvl_reg       <= sirq_pkg::SIRQ_LEVEL_RESET;
         mgmt_sync_reg <= 2'h3;
      end else begin
         line_sync_reg <= {line_sync_reg[0], link.line_level};
         mgmt_sync_reg <= {mgmt_sync_reg[0], mgmt_interrupt_request_in};
         lvl_sync1_reg <= irq_level_in;
         lvl_reg       <= lvl_sync1_reg;
      end
   end

   // low-time counter measures start and stop pulses
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         low_cnt_reg <= sirq_pkg::SIRQ_CNT_RESET;
      end else if (!line_reg) begin
         if (low_cnt_reg != 4'hF) begin
            low_cnt_reg <= low_cnt_reg + 4'h1;
         end
      end else begin
         low_cnt_reg <= sirq_pkg::SIRQ_CNT_RESET;
      end
   end

   // mode: changes only at a stop pulse's rising edge
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         quiet_reg <= 1'b0;
      end else if (state_reg == sirq_pkg::SIRQ_DEV_STOP && rise) begin
         if (low_cnt_reg == 4'(sirq_pkg::SIRQ_STOP_QUIET)) begin
            quiet_reg <= 1'b1;
         end else if (low_cnt_reg == 4'(sirq_pkg::SIRQ_STOP_CONT)) begin
            quiet_reg <= 1'b0;
         end
      end
   end

   // cycle tracking and slot driving
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         state_reg     <= sirq_pkg::SIRQ_DEV_IDLE;
         phase_reg     <= 2'h0;
         period_reg    <= 5'h0;
         drove_low_reg <= 1'b0;
         drv_out_reg   <= 1'b1;
         drv_oe_reg    <= 1'b0;
         sent_reg      <= sirq_pkg::SIRQ_LEVEL_RESET;
      end else begin
         drv_oe_reg  <= 1'b0;
         drv_out_reg <= 1'b1;
         case (state_reg)
            sirq_pkg::SIRQ_DEV_IDLE: begin
               if (!line_reg) begin
                  state_reg <= sirq_pkg::SIRQ_DEV_WAIT;
               end else if (quiet_reg && (slot_lvl != sent_reg)) begin
                  drv_oe_reg  <= 1'b1;
                  drv_out_reg <= 1'b0;
                  state_reg   <= sirq_pkg::SIRQ_DEV_START;
               end
            end
            sirq_pkg::SIRQ_DEV_START: begin
               // one clock only, then released, never driven high
               state_reg <= sirq_pkg::SIRQ_DEV_WAIT;
            end
            sirq_pkg::SIRQ_DEV_WAIT: begin
               // own one-clock pulse is too short to count as the start edge
               if (rise && low_cnt_reg >= 4'(sirq_pkg::SIRQ_START_MIN)) begin
                  // edge seen two clocks late: next clock drives slot 1's sample
                  phase_reg  <= 2'h0;
                  period_reg <= 5'h1;
                  state_reg  <= sirq_pkg::SIRQ_DEV_DATA;
               end
            end
            sirq_pkg::SIRQ_DEV_DATA: begin
               phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
               if (phase_reg == 2'h2) begin
                  period_reg <= period_reg + 5'h1;
               end
               // drive one clock early so the wire is low at 3n-1
               if (phase_reg == 2'h0 && period_reg < 5'(sirq_pkg::SIRQ_PERIODS)) begin
                  drove_low_reg <= slot_low;
                  drv_oe_reg    <= slot_low;
                  drv_out_reg   <= 1'b0;
                  sent_reg[period_reg[3:0]] <= slot_lvl[period_reg[3:0]];
               end else if (phase_reg == 2'h1 && drove_low_reg) begin
                  drv_oe_reg    <= 1'b1;
                  drv_out_reg   <= 1'b1;
                  drove_low_reg <= 1'b0;
               end
               if (period_reg >= 5'(sirq_pkg::SIRQ_PERIODS) && phase_reg == 2'h2) begin
                  state_reg <= sirq_pkg::SIRQ_DEV_STOP;
               end
            end
            sirq_pkg::SIRQ_DEV_STOP: begin
               // extra host frames read high here; stop ends on a 2..3 pulse
               if (rise && (low_cnt_reg == 4'(sirq_pkg::SIRQ_STOP_QUIET) ||
                            low_cnt_reg == 4'(sirq_pkg::SIRQ_STOP_CONT))) begin
                  state_reg <= sirq_pkg::SIRQ_DEV_IDLE;
               end
            end
            default: state_reg <= sirq_pkg::SIRQ_DEV_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         mgmt_line_reg <= 1'b1;
      end else begin
         mgmt_line_reg <= ~(mgmt_pin_en_in & ~mgmt_sync_reg[1]);
      end
   end

   assign link.dev_line_out     = drv_out_reg;
   assign link.dev_line_oe      = drv_oe_reg;
   assign mgmt_interrupt_line_out = mgmt_line_reg;
   assign quiet_mode_out        = quiet_reg;
endmodule
`default_nettype wire

// ### core/sirq_pkg.sv
// constants and types shared by both ends of the serial interrupt link
// What this block does
// - quiet start: device pulls low one clock
// - no start while a cycle runs
// - host holds start low four to eight
// - level change in quiet mode requests start
// - continuous mode: only host starts cycles
// - mode changes at stop; reset continuous
// - stop is two or three low clocks
// - two-clock stop selects quiet mode
// - three-clock stop selects continuous mode
// - frames of three clocks after start edge
// - sample phase: drive low if level low
// - recovery drives high after low; turnaround releases
// - report low levels whoever started cycle
// - frame n sampled 3n-1 after start edge
// - period three carries management or irq2; the device sends them in period 2
// - period fourteen carries irq13; the device sends it in period 13
// - two enables route management interrupt
// - only host ends cycle with stop
// - host runs at least seventeen frames
// - drive and sample on rising edges
// - released during reset; slaves start continuous
// - host runs first cycle after reset
package sirq_pkg;
   localparam int          SIRQ_PERIODS      = 16;
   localparam int          SIRQ_MIN_FRAMES   = 17;
   localparam int          SIRQ_FRAME_CLKS   = 3;
   localparam int          SIRQ_STOP_QUIET   = 2;
   localparam int          SIRQ_STOP_CONT    = 3;
   localparam int          SIRQ_START_MIN    = 4;
   localparam int          SIRQ_START_MAX    = 8;
   localparam int          SIRQ_MGMT_PERIOD  = 3;
   localparam logic [3:0]  SIRQ_CNT_RESET    = 4'h0;
   localparam logic [15:0] SIRQ_LEVEL_RESET  = 16'hFFFF;

   typedef enum logic [2:0] {
      SIRQ_DEV_IDLE  = 3'b000,
      SIRQ_DEV_START = 3'b001,
      SIRQ_DEV_WAIT  = 3'b011,
      SIRQ_DEV_DATA  = 3'b010,
      SIRQ_DEV_STOP  = 3'b110
   } sirq_dev_state_t;

   typedef enum logic [2:0] {
      SIRQ_HST_IDLE  = 3'b000,
      SIRQ_HST_START = 3'b001,
      SIRQ_HST_HIGH  = 3'b011,
      SIRQ_HST_DATA  = 3'b010,
      SIRQ_HST_STOP  = 3'b110,
      SIRQ_HST_SHIGH = 3'b111,
      SIRQ_HST_GAP   = 3'b101
   } sirq_hst_state_t;
endpackage

// ### core/sirq_if.sv
// shared serial interrupt wire with open drivers from both ends
`timescale 1ns/10ps
`default_nettype none
interface sirq_if;
   logic dev_line_out;
   logic dev_line_oe;
   logic hst_line_out;
   logic hst_line_oe;
   logic line_level;

   // pulled high when nobody drives
   assign line_level = dev_line_oe ? dev_line_out : (hst_line_oe ? hst_line_out : 1'b1);

   modport device (
      output dev_line_out,
      output dev_line_oe,
      input  line_level
   );
   modport host (
      output hst_line_out,
      output hst_line_oe,
      input  line_level
   );
endinterface
`default_nettype wire

// ### core/sirq_host.sv
// host end: runs start, data and stop frames and collects levels
`timescale 1ns/10ps
`default_nettype none
module sirq_host #(
   parameter int START_CLKS = 4,
   parameter int FRAMES     = 17
) (
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        reset_in,
   // control
   input  wire logic        quiet_req_in,
   input  wire logic        run_in,
   // collected levels, low means asserted
   output logic [15:0]      irq_level_out,
   output logic             cycle_done_out,
   // link
   sirq_if.host             link
);
   sirq_pkg::sirq_hst_state_t state_reg;
   logic [1:0]  line_sync_reg;
   logic [5:0]  cnt_reg;
   logic [7:0]  clk_reg;
   logic        quiet_reg;
   logic        first_reg;
   logic        out_reg;
   logic        oe_reg;
   logic [15:0] lvl_reg;
   logic        done_reg;

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         line_sync_reg <= 2'h3;
      end else begin
         line_sync_reg <= {line_sync_reg[0], link.line_level};
      end
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         state_reg <= sirq_pkg::SIRQ_HST_IDLE;
         cnt_reg   <= 6'h0;
         clk_reg   <= 8'h0;
         quiet_reg <= 1'b0;
         first_reg <= 1'b1;
         out_reg   <= 1'b1;
         oe_reg    <= 1'b0;
         lvl_reg   <= sirq_pkg::SIRQ_LEVEL_RESET;
         done_reg  <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         clk_reg  <= clk_reg + 8'h1;
         case (state_reg)
            sirq_pkg::SIRQ_HST_IDLE: begin
               oe_reg <= 1'b0;
               // slave start seen low, or own start; first cycle after reset
               if (first_reg || run_in || (quiet_reg && !line_sync_reg[1])) begin
                  oe_reg    <= 1'b1;
                  out_reg   <= 1'b0;
                  cnt_reg   <= 6'h1;
                  first_reg <= 1'b0;
                  state_reg <= sirq_pkg::SIRQ_HST_START;
               end
            end
            sirq_pkg::SIRQ_HST_START: begin
               cnt_reg <= cnt_reg + 6'h1;
               if (cnt_reg >= 6'(START_CLKS)) begin
                  out_reg   <= 1'b1;
                  state_reg <= sirq_pkg::SIRQ_HST_HIGH;
               end
            end
            sirq_pkg::SIRQ_HST_HIGH: begin
               oe_reg    <= 1'b0;
               clk_reg   <= 8'h2;
               state_reg <= sirq_pkg::SIRQ_HST_DATA;
            end
            sirq_pkg::SIRQ_HST_DATA: begin
               // sample in clock 3n-1, seen two flops later
               if (clk_reg >= 8'h4 && (clk_reg - 8'h4) % 8'h3 == 8'h0 &&
                   (clk_reg - 8'h1) / 8'h3 <= 8'd16) begin
                  lvl_reg[4'((clk_reg - 8'h4) / 8'h3)] <= line_sync_reg[1];
               end
               if (clk_reg >= 8'(3 * FRAMES + 1)) begin
                  oe_reg    <= 1'b1;
                  out_reg   <= 1'b0;
                  cnt_reg   <= 6'h1;
                  quiet_reg <= quiet_req_in;
                  state_reg <= sirq_pkg::SIRQ_HST_STOP;
               end
            end
            sirq_pkg::SIRQ_HST_STOP: begin
               cnt_reg <= cnt_reg + 6'h1;
               if (cnt_reg >= 6'(quiet_reg ? sirq_pkg::SIRQ_STOP_QUIET :
                                             sirq_pkg::SIRQ_STOP_CONT)) begin
                  out_reg   <= 1'b1;
                  state_reg <= sirq_pkg::SIRQ_HST_SHIGH;
               end
            end
            sirq_pkg::SIRQ_HST_SHIGH: begin
               oe_reg    <= 1'b0;
               done_reg  <= 1'b1;
               state_reg <= sirq_pkg::SIRQ_HST_GAP;
            end
            sirq_pkg::SIRQ_HST_GAP: begin
               // a new start only from the third clock after the stop edge
               state_reg <= sirq_pkg::SIRQ_HST_IDLE;
            end
            default: state_reg <= sirq_pkg::SIRQ_HST_IDLE;
         endcase
      end
   end

   assign link.hst_line_out = out_reg;
   assign link.hst_line_oe  = oe_reg;
   assign irq_level_out     = lvl_reg;
   assign cycle_done_out    = done_reg;
endmodule
`default_nettype wire

// ### verif/sirq_link_sva.sv
// assertions watching the shared serial interrupt wire
`timescale 1ns/10ps
`default_nettype none
module sirq_link_sva (
   // clock and reset
   input wire logic clock_in,
   input wire logic reset_in,
   // drivers and resolved level
   input wire logic dev_line_out,
   input wire logic dev_line_oe,
   input wire logic hst_line_out,
   input wire logic hst_line_oe,
   input wire logic line_level
);
   logic [3:0] low_cnt_reg;
   logic       dev_low;
   logic       hst_low;
   assign dev_low = dev_line_oe & ~dev_line_out;
   assign hst_low = hst_line_oe & ~hst_line_out;
   // saturating count of low clocks, tells start from stop from sample
   always_ff @(posedge clock_in) begin
      if (reset_in || line_level) begin
         low_cnt_reg <= 4'h0;
      end else if (low_cnt_reg != 4'hF) begin
         low_cnt_reg <= low_cnt_reg + 4'h1;
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (reset_in);
   AST_RESET_RELEASED: assert property (
      $past(reset_in) |-> !dev_line_oe && !hst_line_oe)
      else $error("wire driven right after reset");
   AST_DEV_HIGH_AFTER_LOW: assert property (
      dev_line_oe && dev_line_out |-> $past(dev_low))
      else $error("device drove high without a low before");
   AST_DEV_FRAME_SPACING: assert property (
      dev_low |=> !dev_low [*2])
      else $error("device low drives closer than one frame");
   AST_DEV_TURNAROUND: assert property (
      dev_line_oe && dev_line_out |=> !dev_line_oe)
      else $error("device kept driving in turnaround");
   AST_NO_CONTENTION: assert property (
      !(dev_line_oe && hst_line_oe && dev_line_out != hst_line_out))
      else $error("both ends drive opposite levels");
   AST_LOW_BOUND: assert property (
      low_cnt_reg <= 4'h8)
      else $error("wire low longer than eight clocks");
   AST_HOST_HIGH_AFTER_LOW: assert property (
      hst_low ##1 !hst_low |-> hst_line_oe && hst_line_out)
      else $error("host released low pulse without driving high");
   AST_HOST_HIGH_ONE: assert property (
      hst_line_oe && hst_line_out |=> !hst_line_oe)
      else $error("host drove high more than one clock");
   AST_PERIOD1_SILENT: assert property (
      line_level && low_cnt_reg >= 4'h4 |-> !dev_low ##1 !dev_low ##1 !dev_low)
      else $error("device drove before its first slot");
   AST_STOP_NO_START: assert property (
      line_level && (low_cnt_reg == 4'h2 || low_cnt_reg == 4'h3) |-> !dev_low)
      else $error("device started on stop rising edge");
endmodule
`default_nettype wire

// ### verif/serial_irq_slave_tb.sv
// self-checking bench joining both ends of the serial interrupt link
`timescale 1ns/10ps
`default_nettype none
module serial_irq_slave_tb;
   logic        clock_in = 1'b0;
   logic        reset_in = 1'b1;
   logic [15:0] irq_level = 16'hFFFF;
   logic        mgmt_req = 1'b1;
   logic        frame_en = 1'b0;
   logic        pin_en = 1'b0;
   logic        quiet_req = 1'b0;
   logic        run = 1'b1;
   logic        mgmt_line;
   logic        quiet_mode;
   logic [15:0] host_levels;
   logic        done;
   int          fails = 0;
   int          checks_done = 0;
   logic [15:0] corner [3] = '{16'h0000, 16'hFFFF, 16'hDFFF};
   sirq_if link();
   sirq_device i_sirq_device (.clock_in(clock_in), .reset_in(reset_in), .irq_level_in(irq_level),
      .mgmt_interrupt_request_in(mgmt_req), .mgmt_frame_en_in(frame_en), .mgmt_pin_en_in(pin_en),
      .mgmt_interrupt_line_out(mgmt_line), .quiet_mode_out(quiet_mode), .link(link));
   sirq_host #(.START_CLKS(4), .FRAMES(17)) i_sirq_host (.clock_in(clock_in), .reset_in(reset_in),
      .quiet_req_in(quiet_req), .run_in(run), .irq_level_out(host_levels),
      .cycle_done_out(done), .link(link));
   sirq_link_sva i_sirq_link_sva (.clock_in(clock_in), .reset_in(reset_in),
      .dev_line_out(link.dev_line_out), .dev_line_oe(link.dev_line_oe),
      .hst_line_out(link.hst_line_out), .hst_line_oe(link.hst_line_oe),
      .line_level(link.line_level));
   always #50 clock_in = ~clock_in;
   task automatic complete_run();
      if (fails == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask
   // slot two merges irq2 with the management request when framed
   function automatic logic [15:0] expect_levels(logic [15:0] lv, logic req, logic fen);
      logic [15:0] e;
      e = lv;
      e[2] = lv[2] & (req | ~fen);
      return e;
   endfunction
   task automatic check_levels();
      logic [15:0] e;
      e = expect_levels(irq_level, mgmt_req, frame_en);
      check("irq_level_out", {e[15:1], 1'b0}, {host_levels[15:1], 1'b0});
      check("mgmt_interrupt_line_out", {15'h0000, mgmt_req | ~pin_en},
            {15'h0000, mgmt_line});
   endtask
   task automatic count_done(input int n, output int seen);
      seen = 0;
      repeat (n) begin
         @(posedge clock_in);
         #1;
         if (done === 1'b1) seen++;
      end
   endtask
   task automatic wait_done(input int times);
      int k;
      for (int t = 0; t < times; t++) begin
         k = 0;
         do begin
            @(posedge clock_in);
            #1;
            k++;
         end while (done !== 1'b1 && k < 400);
         if (done !== 1'b1) begin
            $display("Error cycle_done_out expected 1 seen %b", done);
            fails++;
            complete_run();
         end
      end
   endtask
   initial begin
      int seen;
      void'($urandom(63156));
      repeat (8) @(negedge clock_in);
      reset_in = 1'b0;
      // continuous mode, random levels with corner patterns first
      for (int i = 0; i < 12; i++) begin
         @(negedge clock_in);
         irq_level = (i < 3) ? corner[i] : 16'($urandom);
         mgmt_req = 1'($urandom);
         frame_en = 1'($urandom);
         pin_en = 1'($urandom);
         wait_done(2);
         check_levels();
         check("quiet_mode_out", 16'h0000, {15'h0000, quiet_mode});
      end
      @(negedge clock_in);
      quiet_req = 1'b1;
      mgmt_req = 1'b1;
      wait_done(2);
      @(negedge clock_in);
      run = 1'b0;
      // mode flips a few clocks after the stop edge through the synchroniser
      repeat (4) @(negedge clock_in);
      check("quiet_mode_out", 16'h0001, {15'h0000, quiet_mode});
      count_done(150, seen);
      check("idle cycles", 16'h0000, 16'(seen));
      count_done(150, seen);
      check("idle cycles", 16'h0000, 16'(seen));
      // only level changes may start cycles now
      for (int i = 0; i < 4; i++) begin
         @(negedge clock_in);
         irq_level[1 + ($urandom % 15)] ^= 1'b1;
         wait_done(1);
         check_levels();
      end
      @(negedge clock_in);
      irq_level[3] ^= 1'b1;
      repeat (20) @(negedge clock_in);
      reset_in = 1'b1;
      repeat (8) @(negedge clock_in);
      check("quiet_mode_out", 16'h0000, {15'h0000, quiet_mode});
      check("irq_level_out", 16'hFFFF, host_levels);
      quiet_req = 1'b0;
      run = 1'b1;
      reset_in = 1'b0;
      wait_done(1);
      check_levels();
      @(negedge clock_in);
      run = 1'b0;
      count_done(150, seen);
      check("idle cycles", 16'h0000, 16'(seen));
      irq_level[5] ^= 1'b1;
      count_done(150, seen);
      check("idle cycles", 16'h0000, 16'(seen));
      complete_run();
   end
endmodule
`default_nettype wire
